// File: inc/spi_opt_defines.svh
// offsets, field positions and reset values of the spi option/rate block
// Functional notes
// R1: option register bits 7,6,5,2 read zero
// R2: slave mode: select pin is select input
// R3: master, fault detect off: pin to gpio
// R4: master, fault detect on: spi owns pin
// R5: single wire: driver follows bidir output enable
// R6: two wire mode ignores bidir output enable
// R7: two wire mode: separate in/out pins
// R8: single wire slave uses slave data pin
// R9: single wire master uses master data pin
// R10: wait stop bit halts clocks in wait
// R11: rate register accessible at any time
// R12: prescale divides by code plus one
// R13: second divider divides by 2^(code+1)
// R14: master bit clock is second divider output
// R15: select output enable picks fault in/out
`ifndef SPI_OPT_DEFINES_SVH
`define SPI_OPT_DEFINES_SVH
// register byte offsets
`define OPT_CTRL_OFS  8'h00
`define RATE_SEL_OFS  8'h04
`define MODE_CTRL_OFS 8'h08
`define PIN_STAT_OFS  8'h0C
// option control fields
`define OPT_FDE_BIT   4
`define OPT_BOE_BIT   3
`define OPT_WCS_BIT   1
`define OPT_SWS_BIT   0
`define OPT_CTRL_MASK 8'h1B
// bit rate fields
`define RATE_PRE_LSB  4
`define RATE_DIV_LSB  0
`define RATE_SEL_MASK 8'h77
// mode control fields
`define MODE_MS_BIT   0
`define MODE_SOE_BIT  1
`define MODE_CTRL_MASK 8'h03
// reset values
`define OPT_CTRL_RST  8'h00
`define RATE_SEL_RST  8'h00
`define MODE_CTRL_RST 8'h00
// axi responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// File: inc/spi_opt_pkg.sv
// types shared by the spi option and rate block
package spi_opt_pkg;
  // register selected by an address
  typedef enum logic [2:0] {
    REG_OPT, REG_RATE, REG_MODE, REG_STAT, REG_NONE
  } reg_sel_t;
  // function of the slave select pin
  typedef enum logic [1:0] {
    SS_SLAVE_IN, SS_GPIO, SS_FAULT_IN, SS_AUTO_OUT
  } ss_role_t;
endpackage : spi_opt_pkg

// File: logic/rate_divider.sv
// two stage bit rate divider: prescaler then power of two divider
`timescale 1ns/1ps
module rate_divider #(
  parameter int PRE_W = 3,
  parameter int DIV_W = 3
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             run,
  input  wire logic [PRE_W-1:0] prescale_code,
  input  wire logic [DIV_W-1:0] rate_divider_code,
  // one cycle pulse at the bit rate
  output logic                  tick
);
  import spi_opt_pkg::*;

  localparam int CNT_W = 2 ** DIV_W;

  // whole module state
  typedef struct packed {
    logic [PRE_W-1:0] pre_cnt;  // prescale count
    logic [CNT_W-1:0] div_cnt;  // divider count
    logic             tick;     // bit rate pulse
  } div_state_t;

  div_state_t s;
  div_state_t n;

  // last count of the divider for a code
  function automatic logic [CNT_W-1:0] div_limit(
    input logic [DIV_W-1:0] c
  );
    logic [CNT_W:0] w;
    w = ((CNT_W+1)'(2) << c) - (CNT_W+1)'(1);
    return w[CNT_W-1:0];
  endfunction : div_limit

  // next state; >= so a lowered code never runs past its limit
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (!run) begin
      n.pre_cnt = '0;
      n.div_cnt = '0;
    end else if (s.pre_cnt >= prescale_code) begin  // R12
      n.pre_cnt = '0;
      if (s.div_cnt >= div_limit(rate_divider_code)) begin  // R13
        n.div_cnt = '0;
        n.tick = 1'b1;
      end else begin
        n.div_cnt = s.div_cnt + CNT_W'(1);
      end
    end else begin
      n.pre_cnt = s.pre_cnt + PRE_W'(1);
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_tick_needs_run: assert property (tick |-> $past(run)) // R14
    else $error("bit tick without run");
  chk_tick_min_two: assert property (
    tick && $past(run) && run |=> !tick) // R13
    else $error("bit tick faster than divide by two");
endmodule : rate_divider

// File: logic/spi_option_baud.sv
// spi option control and bit rate generation with an axi4-lite slave
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "spi_opt_defines.svh"
module spi_option_baud #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  // axi4-lite write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // axi4-lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  // axi4-lite read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // processor state
  input  wire logic              cpu_wait,
  // slave select pin level, asynchronous
  input  wire logic              ss_pin_in,
  // slave select pin function
  output spi_opt_pkg::ss_role_t  ss_role,
  output logic                   ss_out_en,
  output logic                   ss_slave_active,
  output logic                   ss_fault_low,
  // data pin functions
  output logic                   mosi_out_en,
  output logic                   miso_out_en,
  output logic                   mosi_in_sel,
  output logic                   miso_in_sel,
  output logic                   mosi_gpio,
  output logic                   miso_gpio,
  // clocks to the rest of the unit
  output logic                   spi_clk_run,
  output logic                   bit_rate_tick
);
  import spi_opt_pkg::*;

  // whole module state
  typedef struct packed {
    logic              ss_s1;     // select pin sync stage 1
    logic              ss_s2;     // select pin sync stage 2
    logic              ss_s3;     // select pin sync stage 3
    logic              ss_lvl;    // filtered select level
    logic [7:0]        opt;       // option control register
    logic [7:0]        rate;      // bit rate select register
    logic [7:0]        mode;      // mode control register
    logic              aw_got;    // write address held
    logic              w_got;     // write data held
    logic [ADDR_W-1:0] wa;        // held write address
    logic [7:0]        wd;        // held write data
    logic              wstb;      // held low lane strobe
    logic              awready;   // address ready
    logic              wready;    // data ready
    logic              bvalid;    // response valid
    logic [1:0]        bresp;     // response code
    logic              arready;   // read address ready
    logic              rvalid;    // read data valid
    logic [7:0]        rdata;     // read data low byte
    logic [1:0]        rresp;     // read response code
    reg_sel_t          rsel;      // register last read
    ss_role_t          ss_role;   // select pin function
    logic              ss_out_en; // select driven as output
    logic              ss_act;    // selected as slave
    logic              ss_flt;    // fault input low
    logic              mosi_oe;   // master data pin driver
    logic              miso_oe;   // slave data pin driver
    logic              mosi_in;   // data in from master pin
    logic              miso_in;   // data in from slave pin
    logic              mosi_gp;   // master pin released
    logic              miso_gp;   // slave pin released
    logic              clk_run;   // unit clocks running
    logic              run;       // bit rate divider runs
  } opt_state_t;

  opt_state_t s;
  opt_state_t n;
  logic       wr_go;    // held write is performed
  reg_sel_t   wsel;     // register of held write
  reg_sel_t   rsel_in;  // register of read request
  logic       master;   // master operation
  logic       single;   // single wire operation
  logic       boe;      // bidir output enable
  logic       fde;      // fault detect enable
  logic       soe;      // select output enable
  logic [7:0] status;   // pin status byte

  // byte address to register, shared by both channels
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(`OPT_CTRL_OFS)) begin
      return REG_OPT;
    end else if (a == ADDR_W'(`RATE_SEL_OFS)) begin
      return REG_RATE;
    end else if (a == ADDR_W'(`MODE_CTRL_OFS)) begin
      return REG_MODE;
    end else if (a == ADDR_W'(`PIN_STAT_OFS)) begin
      return REG_STAT;
    end
    return REG_NONE;
  endfunction : decode

  // configuration taken from the registers
  assign master = s.mode[`MODE_MS_BIT];
  assign soe    = s.mode[`MODE_SOE_BIT];
  assign fde    = s.opt[`OPT_FDE_BIT];
  assign boe    = s.opt[`OPT_BOE_BIT];
  assign single = s.opt[`OPT_SWS_BIT];
  assign status = {1'b0, s.ss_lvl, s.mosi_oe | s.miso_oe, single,
                   s.ss_out_en, s.ss_flt, s.mosi_gp | s.miso_gp,
                   s.clk_run};

  // next state of the whole block
  always_comb begin
    n = s;
    wr_go = 1'b0;
    wsel = decode(s.wa);
    rsel_in = decode(araddr);
    // three stage sync; level moves once stages 2 and 3 agree
    n.ss_s1 = ss_pin_in;
    n.ss_s2 = s.ss_s1;
    n.ss_s3 = s.ss_s2;
    if (s.ss_s2 == s.ss_s3) begin
      n.ss_lvl = s.ss_s3;
    end
    // take write address and data in either order
    if (awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.wa = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wd = wdata[7:0];
      n.wstb = wstrb[0];
    end
    // response taken by master
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    // perform write once both halves are held
    if (s.aw_got && s.w_got && !s.bvalid) begin
      wr_go = 1'b1;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wsel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      if (s.wstb) begin
        unique case (wsel)
          REG_OPT: begin
            n.opt = s.wd & `OPT_CTRL_MASK;  // R1
          end
          REG_RATE: begin
            n.rate = s.wd & `RATE_SEL_MASK;  // R11
          end
          REG_MODE: begin
            n.mode = s.wd & `MODE_CTRL_MASK;
          end
          REG_STAT: begin
            // read only, write ignored
          end
          REG_NONE: begin
            // unmapped, answered with error
          end
        endcase
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // read channel, answered one cycle after the request
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rsel = rsel_in;
      n.rresp = (rsel_in == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      unique case (rsel_in)
        REG_OPT: begin
          n.rdata = s.opt & `OPT_CTRL_MASK;  // R1
        end
        REG_RATE: begin
          n.rdata = s.rate;  // R11
        end
        REG_MODE: begin
          n.rdata = s.mode;
        end
        REG_STAT: begin
          n.rdata = status;
        end
        REG_NONE: begin
          n.rdata = 8'h00;
        end
      endcase
    end
    n.arready = !n.rvalid;
    // slave select pin function
    if (!master) begin
      n.ss_role = SS_SLAVE_IN;  // R2
    end else if (!fde) begin
      n.ss_role = SS_GPIO;  // R3
    end else if (!soe) begin
      n.ss_role = SS_FAULT_IN;  // R4 R15
    end else begin
      n.ss_role = SS_AUTO_OUT;  // R4 R15
    end
    n.ss_out_en = master && fde && soe;  // R15
    n.ss_act = !master && !s.ss_lvl;
    n.ss_flt = master && fde && !soe && !s.ss_lvl;
    // data pin functions
    if (!single) begin
      // separate pins, bidir enable has no say
      n.mosi_oe = master;  // R6 R7
      n.miso_oe = !master;  // R6 R7
      n.mosi_in = !master;  // R7
      n.miso_in = master;  // R7
      n.mosi_gp = 1'b0;
      n.miso_gp = 1'b0;
    end else if (master) begin
      // shared data on the master pin
      n.mosi_oe = boe;  // R5 R9
      n.miso_oe = 1'b0;
      n.mosi_in = 1'b1;  // R9
      n.miso_in = 1'b0;
      n.mosi_gp = 1'b0;
      n.miso_gp = 1'b1;
    end else begin
      // shared data on the slave pin
      n.mosi_oe = 1'b0;
      n.miso_oe = boe;  // R5 R8
      n.mosi_in = 1'b0;
      n.miso_in = 1'b1;  // R8
      n.mosi_gp = 1'b1;
      n.miso_gp = 1'b0;
    end
    // clocks halt in wait only when asked to
    n.clk_run = !(s.opt[`OPT_WCS_BIT] && cpu_wait);  // R10
    n.run = master && n.clk_run;  // R14
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ss_s1 <= 1'b1;
      s.ss_s2 <= 1'b1;
      s.ss_s3 <= 1'b1;
      s.ss_lvl <= 1'b1;
      s.opt <= `OPT_CTRL_RST;
      s.rate <= `RATE_SEL_RST;
      s.mode <= `MODE_CTRL_RST;
      s.rsel <= REG_NONE;
      s.ss_role <= SS_SLAVE_IN;
      s.miso_oe <= 1'b1;
      s.mosi_in <= 1'b1;
      s.clk_run <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // master bit rate from prescaler and power of two divider
  rate_divider #(
    .PRE_W (3),
    .DIV_W (3)
  ) u_rate (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .run               (s.run),
    .prescale_code     (s.rate[`RATE_PRE_LSB +: 3]),
    .rate_divider_code (s.rate[`RATE_DIV_LSB +: 3]),
    .tick              (bit_rate_tick)
  );

  // outputs straight from the state register
  assign awready         = s.awready;
  assign wready          = s.wready;
  assign bvalid          = s.bvalid;
  assign bresp           = s.bresp;
  assign arready         = s.arready;
  assign rvalid          = s.rvalid;
  assign rdata           = {24'h000000, s.rdata};
  assign rresp           = s.rresp;
  assign ss_role         = s.ss_role;
  assign ss_out_en       = s.ss_out_en;
  assign ss_slave_active = s.ss_act;
  assign ss_fault_low    = s.ss_flt;
  assign mosi_out_en     = s.mosi_oe;
  assign miso_out_en     = s.miso_oe;
  assign mosi_in_sel     = s.mosi_in;
  assign miso_in_sel     = s.miso_in;
  assign mosi_gpio       = s.mosi_gp;
  assign miso_gpio       = s.miso_gp;
  assign spi_clk_run     = s.clk_run;

  // checking helpers: cycles between bit ticks
  logic [11:0] gap;       // cycles since last tick
  logic        clean;     // settings stable since a tick
  logic [7:0]  prev_rate; // rate register one cycle ago
  logic [11:0] period;    // expected tick spacing

  assign period = (12'(s.rate[`RATE_PRE_LSB +: 3]) + 12'h001)
                  << (12'(s.rate[`RATE_DIV_LSB +: 3]) + 12'h001);

  // helper counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 12'h000;
      clean <= 1'b0;
      prev_rate <= 8'h00;
    end else begin
      prev_rate <= s.rate;
      if (!s.run || prev_rate != s.rate) begin
        gap <= 12'h000;
        clean <= 1'b0;
      end else if (bit_rate_tick) begin
        gap <= 12'h000;
        clean <= 1'b1;
      end else begin
        gap <= gap + 12'h001;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_opt_reserved_zero: assert property ( // R1
    rvalid && s.rsel == REG_OPT |-> (rdata[7:5] == 3'h0 && !rdata[2]))
    else $error("option reserved bits not zero");
  chk_slave_ss_in: assert property ( // R2
    !master |=> ss_role == SS_SLAVE_IN && !ss_out_en)
    else $error("slave select not input in slave");
  chk_master_ss_gpio: assert property ( // R3
    master && !fde |=> ss_role == SS_GPIO && !ss_out_en)
    else $error("select pin not released");
  chk_ss_fault_out: assert property ( // R15
    master && fde |=> (ss_out_en == $past(soe)) &&
    (ss_role == ($past(soe) ? SS_AUTO_OUT : SS_FAULT_IN)))
    else $error("select pin function wrong");
  chk_bidir_driver: assert property ( // R5
    single |=> (mosi_out_en | miso_out_en) == $past(boe))
    else $error("bidir driver not following enable");
  chk_two_wire_pins: assert property ( // R7
    !single |=> mosi_in_sel != miso_in_sel &&
    mosi_out_en != miso_out_en && mosi_out_en == $past(master))
    else $error("two wire pins wrong");
  chk_slave_bidir_pin: assert property ( // R8
    single && !master |=> miso_in_sel && !mosi_in_sel && !mosi_out_en)
    else $error("slave bidir pin wrong");
  chk_master_bidir_pin: assert property ( // R9
    single && master |=> mosi_in_sel && miso_gpio && !miso_out_en)
    else $error("master bidir pin wrong");
  chk_wait_clock_stop: assert property ( // R10
    s.opt[`OPT_WCS_BIT] && cpu_wait |=> !spi_clk_run ##1
    (spi_clk_run == !$past(s.opt[`OPT_WCS_BIT] && cpu_wait)))
    else $error("wait clock stop wrong");
  chk_rate_write: assert property ( // R11
    wr_go && wsel == REG_RATE && s.wstb |=> ##1
    rvalid || (s.rate == ($past(s.wd, 2) & `RATE_SEL_MASK)))
    else $error("rate write lost");
  chk_tick_period: assert property ( // R13
    bit_rate_tick && clean && $past(s.run) |-> gap == period - 12'h001)
    else $error("bit tick spacing wrong");
  chk_tick_master: assert property ( // R14
    bit_rate_tick |-> $past(s.run, 2) || $past(master, 2))
    else $error("bit tick outside master");

  cov_single_master: cover property (single && master && boe);
  cov_fault_input: cover property (ss_fault_low);
  cov_slow_tick: cover property (bit_rate_tick && period == 12'h800);
  cov_clock_halt: cover property (!spi_clk_run);
  cov_slverr: cover property (bvalid && bresp == `RESP_SLVERR);
endmodule : spi_option_baud

// File: tb/spi_far_end.sv
// far side device: drives the slave select pin of the unit
`timescale 1ns/1ps
module spi_far_end (
  // clock
  input  wire logic aclk,
  // bench request to select the unit
  input  wire logic sel_req,
  // unit drives the select pin itself
  input  wire logic ss_out_en,
  // pin level seen by the unit
  output logic      ss_pin_in
);
  // registered drive; released pin idles high through its pull-up
  initial ss_pin_in = 1'b1;
  always @(posedge aclk) begin
    ss_pin_in <= (sel_req && !ss_out_en) ? 1'b0 : 1'b1;
  end
endmodule : spi_far_end

// File: tb/testbench.sv
// self-checking bench for the spi option and bit rate block
`timescale 1ns/1ps
module testbench;
  import spi_opt_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        cpu_wait, ss_pin_in, sel_req;
  ss_role_t    ss_role;
  logic        ss_out_en, ss_slave_active, ss_fault_low;
  logic        mosi_out_en, miso_out_en, mosi_in_sel, miso_in_sel;
  logic        mosi_gpio, miso_gpio, spi_clk_run, bit_rate_tick;
  int          bad_count, check_count;
  int          regm [4];            // register model contents
  int          mask [4] = '{32'h1B, 32'h77, 32'h03, 32'h00};
  logic [15:0] seed;
  // unit under test with one spare address bit for an unmapped place
  spi_option_baud #(.ADDR_W(5)) i_spi_option_baud (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .cpu_wait(cpu_wait), .ss_pin_in(ss_pin_in),
    .ss_role(ss_role), .ss_out_en(ss_out_en),
    .ss_slave_active(ss_slave_active), .ss_fault_low(ss_fault_low),
    .mosi_out_en(mosi_out_en), .miso_out_en(miso_out_en),
    .mosi_in_sel(mosi_in_sel), .miso_in_sel(miso_in_sel),
    .mosi_gpio(mosi_gpio), .miso_gpio(miso_gpio),
    .spi_clk_run(spi_clk_run), .bit_rate_tick(bit_rate_tick));
  // far side device on the select pin
  spi_far_end i_spi_far_end (.aclk(aclk), .sel_req(sel_req),
    .ss_out_en(ss_out_en), .ss_pin_in(ss_pin_in));
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // one comparison
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  // bounded wait ran out
  task automatic hang(input string msg);
    bad_count++;
    $display("mismatch at %0t: timeout %s", $time, msg);
    test_done();
  endtask : hang
  // pseudo random source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // axi4-lite write, address and data offered together
  task automatic axi_write(input logic [4:0] a, input logic [7:0] d,
                           output logic [1:0] resp);
    int n;
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_hs = 1'b0;
    for (n = 0; n < 100 && !b_hs; n++) begin
      @(negedge aclk);
      aw_hs = awvalid & awready;
      w_hs  = wvalid & wready;
      b_hs  = bready & bvalid;
      resp  = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end
    if (!b_hs) hang("write");
  endtask : axi_write
  // axi4-lite read
  task automatic axi_read(input logic [4:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int n;
    logic ar_hs, r_hs;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_hs = 1'b0;
    for (n = 0; n < 100 && !r_hs; n++) begin
      @(negedge aclk);
      ar_hs = arvalid & arready;
      r_hs  = rready & rvalid;
      d     = rdata;
      resp  = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end
    if (!r_hs) hang("read");
  endtask : axi_read
  // write a mapped register and keep the model in step
  task automatic wr(input int idx, input logic [7:0] d);
    logic [1:0] resp;
    axi_write(5'(idx * 4), d, resp);
    check(resp === 2'h0, "write response");
    regm[idx] = d & mask[idx];
  endtask : wr
  // read a mapped register against the model
  task automatic rd(input int idx);
    logic [31:0] d;
    logic [1:0]  resp;
    axi_read(5'(idx * 4), d, resp);
    check(resp === 2'h0 && d === 32'(regm[idx]), "read value");
  endtask : rd
  // cycles between two bit rate ticks
  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (bit_rate_tick !== 1'b1 && n < 5000);
    gap = 0;
    do begin
      @(negedge aclk);
      gap++;
    end while (bit_rate_tick !== 1'b1 && gap < 5000);
    if (gap >= 5000) hang("tick");
  endtask : tick_gap
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  resp;
    logic [6:0]  pin_exp;
    logic [1:0]  role;
    logic        ms, fde, soe, sws, boe;
    int          gap, n;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    cpu_wait = 1'b0;
    sel_req = 1'b0;
    bad_count = 0;
    check_count = 0;
    regm = '{0, 0, 0, 0};
    seed = 16'h459D;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, then all bits set and random values
    for (int i = 0; i < 3; i++) rd(i);
    for (int i = 0; i < 3; i++) begin
      wr(i, 8'hFF);
      rd(i);
      seed = lfsr(seed);
      wr(i, seed[7:0]);
      rd(i);
    end
    // unmapped place answers with an error and reads zero
    axi_write(5'h10, 8'hFF, resp);
    check(resp === 2'h2, "unmapped write");
    axi_read(5'h10, d, resp);
    check(resp === 2'h2 && d === 32'h0, "unmapped read");
    // low lane strobe clear: answered okay, nothing stored
    wstrb <= 4'hE;
    axi_write(5'h04, 8'h55, resp);
    check(resp === 2'h0, "strobe off write");
    wstrb <= 4'hF;
    rd(1);
    // every combination of the pin control bits
    for (int i = 0; i < 32; i++) begin
      {boe, sws, soe, fde, ms} = 5'(i);
      wr(0, {3'h0, fde, boe, 2'h0, sws});
      wr(2, {6'h0, soe, ms});
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      role = !ms ? 2'h0 : (!fde ? 2'h1 : (soe ? 2'h3 : 2'h2));
      pin_exp = {role, role == 2'h3, ms & (!sws | boe),
                 !ms & (!sws | boe), sws & !ms, sws & ms};
      check({ss_role, ss_out_en, mosi_out_en, miso_out_en, mosi_gpio,
             miso_gpio} === pin_exp, "pin roles");
      if (!sws) begin
        check({mosi_in_sel, miso_in_sel} === {!ms, ms}, "input pin");
      end else begin
        check({mosi_in_sel, miso_in_sel} === {ms, !ms}, "bidir pin");
      end
      check({ss_slave_active, ss_fault_low} === 2'h0, "select idle");
    end
    // select pin through the synchroniser: slave, then fault input
    wr(0, 8'h00);
    wr(2, 8'h00);
    sel_req <= 1'b1;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    check(ss_slave_active === 1'b1, "slave select");
    wr(0, 8'h10);
    wr(2, 8'h01);
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    check(ss_fault_low === 1'b1, "fault input");
    @(posedge aclk);
    sel_req <= 1'b0;
    // master bit rate for extreme and random codes
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      d[7:0] = (i == 0) ? 8'h00 : ((i == 1) ? 8'h77 : seed[7:0] & 8'h77);
      wr(1, d[7:0]);
      tick_gap(gap);
      check(gap == (d[6:4] + 1) * (2 << d[2:0]), "tick spacing");
    end
    // clocks in wait mode with the stop bit clear and set
    @(posedge aclk);
    cpu_wait <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check(spi_clk_run === 1'b1, "run in wait");
    wr(0, 8'h12);
    // a tick already launched before the halt may still show once
    @(posedge aclk);
    n = 0;
    repeat (300) begin
      @(negedge aclk);
      if (bit_rate_tick !== 1'b0) n++;
    end
    check(spi_clk_run === 1'b0 && n == 0, "stop in wait");
    @(posedge aclk);
    cpu_wait <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check(spi_clk_run === 1'b1, "run after wait");
    // status: select high, master driver on, clocks running
    axi_read(5'h0C, d, resp);
    check(resp === 2'h0 && d === 32'h61, "status read");
    test_done();
  end
  // overall limit on the run
  initial begin
    repeat (90000) @(posedge aclk);
    hang("run");
  end
endmodule : testbench
